// ==== hdl/pdc_pkg.sv ====
// package: register map, field layout and carriers for port direction control
package pdc_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned SIX_W       = 6;
  localparam int unsigned EIGHT_W     = 8;
  localparam int unsigned REG_W       = 8;

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SIX_DIR    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_EIGHT_DIR  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SIX_DATA   = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_EIGHT_DATA = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_PIN_STATE  = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_MODE       = 12'h014;

  // ==========================================================================
  // reset values
  localparam logic [SIX_W-1:0]   RST_SIX_DIR    = 6'h00;
  localparam logic [EIGHT_W-1:0] RST_EIGHT_DIR  = 8'h00;
  localparam logic [SIX_W-1:0]   RST_SIX_DATA   = 6'h00;
  localparam logic [EIGHT_W-1:0] RST_EIGHT_DATA = 8'h00;
  localparam logic [DATA_W-1:0]  RD_ZERO        = 32'h00000000;

  // ==========================================================================
  // mode register fields
  localparam int unsigned MODE_SINGLE_CHIP = 0;
  localparam int unsigned MODE_EXPANSION   = 1;
  localparam int unsigned MODE_BUS16       = 2;
  localparam int unsigned MODE_W           = 3;
  localparam logic [MODE_W-1:0] RST_MODE   = 3'h0;

  // pin state register fields
  localparam int unsigned PIN_SIX_LSB   = 0;
  localparam int unsigned PIN_EIGHT_LSB = 8;
  localparam int unsigned PIN_OWN_BIT   = 16;

  // ==========================================================================
  // pin carriers
  typedef struct packed {
    logic [SIX_W-1:0] out;
    logic [SIX_W-1:0] oe;
  } pdc_six_pin_t;

  typedef struct packed {
    logic [EIGHT_W-1:0] out;
    logic [EIGHT_W-1:0] oe;
  } pdc_eight_pin_t;

  typedef struct packed {
    logic [SIX_W-1:0] enable;
    logic [SIX_W-1:0] out;
    logic [SIX_W-1:0] oe;
  } pdc_alt_fn_t;

  typedef struct packed {
    logic [EIGHT_W-1:0] out;
    logic [EIGHT_W-1:0] oe;
  } pdc_bus_drive_t;

endpackage

// ==== hdl/pdc_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pdc_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  // ==========================================================================
  // stages
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule

// ==== hdl/pdc_port_direction_control.sv ====
// top: apb slave with direction and data registers for two shared ports
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module pdc_port_direction_control (
  input  wire logic                               core_clk,
  input  wire logic                               rst_n,
  // apb
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [pdc_pkg::ADDR_W-1:0]         paddr,
  input  wire logic [pdc_pkg::DATA_W-1:0]         pwdata,
  output logic      [pdc_pkg::DATA_W-1:0]         prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // six-pin port
  input  wire logic [pdc_pkg::SIX_W-1:0]          sixPinIn,
  output pdc_pkg::pdc_six_pin_t                   sixPin,
  input  wire pdc_pkg::pdc_alt_fn_t               sixAlt,
  output logic      [pdc_pkg::SIX_W-1:0]          sixAltIn,
  // eight-pin port
  input  wire logic [pdc_pkg::EIGHT_W-1:0]        eightPinIn,
  output pdc_pkg::pdc_eight_pin_t                 eightPin,
  // external data bus side
  input  wire pdc_pkg::pdc_bus_drive_t            busDrive,
  output logic      [pdc_pkg::EIGHT_W-1:0]        busDataIn,
  output logic                                    busOwnsPort
);

  // ==========================================================================
  // address decode
  function automatic logic isMapped(input logic [pdc_pkg::ADDR_W-1:0] a);
    isMapped = (a == pdc_pkg::OFF_SIX_DIR)    ||
               (a == pdc_pkg::OFF_EIGHT_DIR)  ||
               (a == pdc_pkg::OFF_SIX_DATA)   ||
               (a == pdc_pkg::OFF_EIGHT_DATA) ||
               (a == pdc_pkg::OFF_PIN_STATE)  ||
               (a == pdc_pkg::OFF_MODE);
  endfunction

  function automatic logic hits(input logic [pdc_pkg::ADDR_W-1:0] a,
                                input logic [pdc_pkg::ADDR_W-1:0] off);
    hits = (a == off);
  endfunction

  // ==========================================================================
  // declarations
  logic                              access;
  logic                              wrStrobe;
  logic [pdc_pkg::SIX_W-1:0]         sixDir;
  logic [pdc_pkg::EIGHT_W-1:0]       eightDir;
  logic [pdc_pkg::SIX_W-1:0]         sixData;
  logic [pdc_pkg::EIGHT_W-1:0]       eightData;
  logic [pdc_pkg::MODE_W-1:0]        mode;
  logic [pdc_pkg::SIX_W-1:0]         sixSync;
  logic [pdc_pkg::EIGHT_W-1:0]       eightSync;
  logic                              next_busOwns;
  logic [pdc_pkg::DATA_W-1:0]        next_prdata;
  logic [pdc_pkg::SIX_W-1:0]         next_sixOut;
  logic [pdc_pkg::SIX_W-1:0]         next_sixOe;
  logic [pdc_pkg::EIGHT_W-1:0]       next_eightOut;
  logic [pdc_pkg::EIGHT_W-1:0]       next_eightOe;

  // ==========================================================================
  // apb handshake
  // zero wait states: pready rises for the single access cycle
  typedef enum {
    BUS_IDLE,
    BUS_ACCESS
  } pdc_bus_state_t;

  pdc_bus_state_t                    busState;
  pdc_bus_state_t                    next_busState;
  logic                              setupPhase;

  // a setup seen while answering is not taken as a second request
  assign setupPhase = psel && !penable && (busState == BUS_IDLE);
  assign access     = psel && penable && pready;
  assign wrStrobe   = access && pwrite;

  always_comb begin
    next_busState = BUS_IDLE;
    case (busState)
      BUS_IDLE: begin
        if (setupPhase) begin
          next_busState = BUS_ACCESS;
        end
      end
      BUS_ACCESS: begin
        next_busState = BUS_IDLE;
      end
      default: begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busState <= BUS_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  // pready mirrors the state but stays a plain flop output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= (next_busState == BUS_ACCESS);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= !isMapped(paddr);
    end else begin
      pslverr <= 1'b0;
    end
  end

  // ==========================================================================
  // direction registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sixDir <= pdc_pkg::RST_SIX_DIR;
    end else if (wrStrobe && hits(paddr, pdc_pkg::OFF_SIX_DIR)) begin
      // reserved upper bits are simply not stored
      sixDir <= pwdata[pdc_pkg::SIX_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eightDir <= pdc_pkg::RST_EIGHT_DIR;
    end else if (wrStrobe && hits(paddr, pdc_pkg::OFF_EIGHT_DIR)) begin
      eightDir <= pwdata[pdc_pkg::EIGHT_W-1:0];
    end
  end

  // ==========================================================================
  // data registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sixData <= pdc_pkg::RST_SIX_DATA;
    end else if (wrStrobe && hits(paddr, pdc_pkg::OFF_SIX_DATA)) begin
      sixData <= pwdata[pdc_pkg::SIX_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eightData <= pdc_pkg::RST_EIGHT_DATA;
    end else if (wrStrobe && hits(paddr, pdc_pkg::OFF_EIGHT_DATA)) begin
      eightData <= pwdata[pdc_pkg::EIGHT_W-1:0];
    end
  end

  // ==========================================================================
  // mode register
  // software sets the operating mode here; a strap would need a sampler
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= pdc_pkg::RST_MODE;
    end else if (wrStrobe && hits(paddr, pdc_pkg::OFF_MODE)) begin
      mode <= pwdata[pdc_pkg::MODE_W-1:0];
    end
  end

  // ==========================================================================
  // read data
  always_comb begin
    next_prdata = pdc_pkg::RD_ZERO;
    case (paddr)
      pdc_pkg::OFF_SIX_DIR: begin
        next_prdata = pdc_pkg::RD_ZERO;
      end
      pdc_pkg::OFF_EIGHT_DIR: begin
        next_prdata = pdc_pkg::RD_ZERO;
      end
      pdc_pkg::OFF_SIX_DATA: begin
        next_prdata[pdc_pkg::SIX_W-1:0] = sixData;
      end
      pdc_pkg::OFF_EIGHT_DATA: begin
        next_prdata[pdc_pkg::EIGHT_W-1:0] = eightData;
      end
      pdc_pkg::OFF_PIN_STATE: begin
        next_prdata[pdc_pkg::PIN_SIX_LSB +: pdc_pkg::SIX_W]     = sixSync;
        next_prdata[pdc_pkg::PIN_EIGHT_LSB +: pdc_pkg::EIGHT_W] = eightSync;
        next_prdata[pdc_pkg::PIN_OWN_BIT]                      = busOwnsPort;
      end
      pdc_pkg::OFF_MODE: begin
        next_prdata[pdc_pkg::MODE_W-1:0] = mode;
      end
      default: begin
        next_prdata = pdc_pkg::RD_ZERO;
      end
    endcase
  end

  // data driven during the access cycle only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= pdc_pkg::RD_ZERO;
    end else if (setupPhase && !pwrite) begin
      prdata <= next_prdata;
    end else begin
      prdata <= pdc_pkg::RD_ZERO;
    end
  end

  // ==========================================================================
  // pin input synchronisers
  pdc_sync #(
    .WIDTH (pdc_pkg::SIX_W)
  ) u_sync_six (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async    (sixPinIn),
    .synced   (sixSync)
  );

  pdc_sync #(
    .WIDTH (pdc_pkg::EIGHT_W)
  ) u_sync_eight (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async    (eightPinIn),
    .synced   (eightSync)
  );

  // ==========================================================================
  // eight-pin port ownership
  always_comb begin
    next_busOwns = 1'b0;
    if (!mode[pdc_pkg::MODE_SINGLE_CHIP]) begin
      next_busOwns = mode[pdc_pkg::MODE_BUS16];
    end else if (mode[pdc_pkg::MODE_EXPANSION]) begin
      next_busOwns = mode[pdc_pkg::MODE_BUS16];
    end else begin
      next_busOwns = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busOwnsPort <= 1'b0;
    end else begin
      busOwnsPort <= next_busOwns;
    end
  end

  // ==========================================================================
  // six-pin drive
  // alternative function takes the pin per bit; otherwise direction decides
  genvar gi;
  generate
    for (gi = 0; gi < pdc_pkg::SIX_W; gi++) begin : g_six
      always_comb begin
        if (sixAlt.enable[gi]) begin
          next_sixOut[gi] = sixAlt.out[gi];
          next_sixOe[gi]  = sixAlt.oe[gi];
        end else begin
          next_sixOut[gi] = sixData[gi] && sixDir[gi];
          next_sixOe[gi]  = sixDir[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sixPin   <= '0;
      sixAltIn <= '0;
    end else begin
      sixPin.out <= next_sixOut;
      sixPin.oe  <= next_sixOe;
      sixAltIn   <= sixSync;
    end
  end

  // ==========================================================================
  // eight-pin drive
  // one cycle of drive lag after a mode change; software must not race it
  generate
    for (gi = 0; gi < pdc_pkg::EIGHT_W; gi++) begin : g_eight
      always_comb begin
        if (next_busOwns) begin
          next_eightOut[gi] = busDrive.out[gi];
          next_eightOe[gi]  = busDrive.oe[gi];
        end else begin
          next_eightOut[gi] = eightData[gi] && eightDir[gi];
          next_eightOe[gi]  = eightDir[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eightPin  <= '0;
      busDataIn <= '0;
    end else begin
      eightPin.out <= next_eightOut;
      eightPin.oe  <= next_eightOe;
      busDataIn    <= eightSync;
    end
  end

endmodule

// ==== sim/pdc_port_direction_control_chk.sv ====
// checker: bus timing and pin control relations of the port block
`timescale 1ns/10ps
module pdc_port_direction_control_chk (
  input wire logic                         core_clk,
  input wire logic                         rst_n,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [pdc_pkg::ADDR_W-1:0]   paddr,
  input wire logic [pdc_pkg::DATA_W-1:0]   pwdata,
  input wire logic [pdc_pkg::DATA_W-1:0]   prdata,
  input wire logic                         pready,
  input wire pdc_pkg::pdc_six_pin_t        sixPin,
  input wire pdc_pkg::pdc_alt_fn_t         sixAlt,
  input wire pdc_pkg::pdc_eight_pin_t      eightPin,
  input wire pdc_pkg::pdc_bus_drive_t      busDrive,
  input wire logic                         busOwnsPort
);
  // ==========================================================================
  // helpers
  logic [7:0] wrByte;
  logic [5:0] wrSix;
  logic       ownNow;
  assign wrByte = pwdata[7:0];
  assign wrSix  = pwdata[5:0];
  // single-chip without expansion keeps the port general
  assign ownNow = pwdata[2] & ~(pwdata[0] & ~pwdata[1]);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // assertions
  ready_after_setup_a:
    assert property (psel && !penable |=> pready) else $error("no ready");
  ready_single_a:
    assert property (pready |=> !pready) else $error("ready held");
  dir_read_zero_a:
    assert property (pready && !pwrite && (paddr == pdc_pkg::OFF_SIX_DIR ||
      paddr == pdc_pkg::OFF_EIGHT_DIR) |-> prdata == pdc_pkg::RD_ZERO)
    else $error("direction read not zero");
  reset_input_a:
    assert property ($rose(rst_n) |-> sixPin == '0 && eightPin == '0)
    else $error("pins not inputs after reset");
  six_dir_pin_a:
    assert property (pready && pwrite && paddr == pdc_pkg::OFF_SIX_DIR &&
      sixAlt.enable == '0 |-> ##2 sixPin.oe == $past(wrSix, 2))
    else $error("six-pin enable wrong");
  eight_dir_pin_a:
    assert property (pready && pwrite && paddr == pdc_pkg::OFF_EIGHT_DIR &&
      !busOwnsPort |-> ##2 eightPin.oe == $past(wrByte, 2))
    else $error("eight-pin enable wrong");
  bus_owner_a:
    assert property (pready && pwrite && paddr == pdc_pkg::OFF_MODE
      |-> ##2 busOwnsPort == $past(ownNow, 2))
    else $error("port owner wrong");
  owned_drive_a:
    assert property (busOwnsPort && $past(busOwnsPort)
      |-> eightPin == $past(busDrive))
    else $error("bus data not on port");
  out_gated_a:
    assert property (!busOwnsPort |-> (eightPin.out & ~eightPin.oe) == '0)
    else $error("input pin shows output");
endmodule

bind pdc_port_direction_control pdc_port_direction_control_chk
  pdc_port_direction_control_chk_inst (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .sixPin(sixPin),
  .sixAlt(sixAlt), .eightPin(eightPin), .busDrive(busDrive),
  .busOwnsPort(busOwnsPort));

// ==== sim/pdc_pin_model.sv ====
// model of the external pins and the bus data source
`timescale 1ns/10ps
module pdc_pin_model (
  input wire logic                    core_clk,
  input wire logic [7:0]              extLevel,
  input wire pdc_pkg::pdc_six_pin_t   sixPin,
  input wire pdc_pkg::pdc_eight_pin_t eightPin,
  output logic     [5:0]              sixPinIn,
  output logic     [7:0]              eightPinIn,
  output pdc_pkg::pdc_bus_drive_t     busDrive
);
  // ==========================================================================
  // pin levels: driven bits win, others follow the outside world
  assign sixPinIn   = (sixPin.oe & sixPin.out) | (~sixPin.oe & extLevel[5:0]);
  assign eightPinIn = (eightPin.oe & eightPin.out) | (~eightPin.oe & extLevel);
  // bus data changes every cycle so a stale copy is seen
  initial busDrive = 16'h003c;
  always @(posedge core_clk) begin
    busDrive.out <= busDrive.out + 8'h01;
  end
endmodule

// ==== sim/pdc_port_direction_control_tb.sv ====
// testbench: register writes, mode table and pin checks
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pdc_port_direction_control_tb;
  logic                          core_clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [pdc_pkg::ADDR_W-1:0]    paddr = '0;
  logic [pdc_pkg::DATA_W-1:0]    pwdata = '0, prdata, rdv;
  logic                          pready, pslverr, errv;
  logic [5:0]                    sixPinIn, sixAltIn;
  logic [7:0]                    eightPinIn, busDataIn, extLevel = 8'h5a;
  pdc_pkg::pdc_six_pin_t         sixPin;
  pdc_pkg::pdc_alt_fn_t          sixAlt = '0;
  pdc_pkg::pdc_eight_pin_t       eightPin;
  pdc_pkg::pdc_bus_drive_t       busDrive;
  logic                          busOwnsPort;
  int                            fails = 0, total_checks = 0, cycles = 0;
  logic [2:0] modes [6] = '{3'h0, 3'h4, 3'h2, 3'h7, 3'h5, 3'h3};
  logic       owns  [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  always #25 core_clk = ~core_clk;
  pdc_port_direction_control pdc_port_direction_control_inst (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sixPinIn(sixPinIn),
    .sixPin(sixPin), .sixAlt(sixAlt), .sixAltIn(sixAltIn),
    .eightPinIn(eightPinIn), .eightPin(eightPin), .busDrive(busDrive),
    .busDataIn(busDataIn), .busOwnsPort(busOwnsPort));
  pdc_pin_model pdc_pin_model_inst (.core_clk(core_clk), .extLevel(extLevel),
    .sixPin(sixPin), .eightPin(eightPin), .sixPinIn(sixPinIn),
    .eightPinIn(eightPinIn), .busDrive(busDrive));
  // ==========================================================================
  // bus tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no local limit: only the cycle guard ends a hung transfer
    do begin @(posedge core_clk); end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    `CHK(rdv, e)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard: whole run is about 70 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin fails++; close_out(); end
  end
  // ==========================================================================
  // tests
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `CHK({sixPin, eightPin}, 28'h0)
    rdchk(pdc_pkg::OFF_EIGHT_DIR, 32'h0);
    $display("test reset done");
    apb(1'b1, pdc_pkg::OFF_SIX_DIR, 32'hff);
    apb(1'b1, pdc_pkg::OFF_SIX_DATA, 32'h2b);
    repeat (2) @(posedge core_clk);
    `CHK(sixPin, {6'h2b, 6'h3f})
    rdchk(pdc_pkg::OFF_SIX_DIR, 32'h0);
    apb(1'b1, pdc_pkg::OFF_SIX_DIR, 32'h05);
    repeat (3) @(posedge core_clk);
    `CHK(sixPin.out, 6'h01)
    rdchk(pdc_pkg::OFF_PIN_STATE, 32'h00005a1b);
    `CHK(sixAltIn, 6'h1b)
    `CHK(busDataIn, 8'h5a)
    sixAlt <= {6'h03, 6'h03, 6'h02};
    repeat (2) @(posedge core_clk);
    `CHK(sixPin.oe, 6'h06)
    sixAlt <= '0;
    $display("test six-pin done");
    apb(1'b1, pdc_pkg::OFF_EIGHT_DIR, 32'ha5);
    apb(1'b1, pdc_pkg::OFF_EIGHT_DATA, 32'h0f);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, pdc_pkg::OFF_MODE, {29'h0, modes[i]});
      repeat (2) @(posedge core_clk);
      `CHK(busOwnsPort, owns[i])
      `CHK(eightPin.oe, owns[i] ? 8'h3c : 8'ha5)
      if (!owns[i]) `CHK(eightPin.out, 8'h05)
    end
    $display("test mode table done");
    rdchk(12'h020, 32'h0);
    `CHK(errv, 1'b1)
    apb(1'b1, 12'h020, 32'hff);
    `CHK(errv, 1'b1)
    $display("test unmapped done");
    close_out();
  end
endmodule
